// *** hw/ict_capture_seq.sv ***
`timescale 1ns/1ps
`include "ict_map.svh"
module ict_capture_seq import ict_pkg::*; #(
  parameter int RATE_WINDOW_CYC = `ICT_RATE_WINDOW_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Host commands, one-cycle strobes
  input wire logic CAPTURE_BEGIN_CMD,
  input wire logic CAPTURE_HALT_CMD,
  input wire logic SOFT_TRIGGER_CMD,
  // Global settings, taken on CFG_WRITE except BURST_FINISH_TRIGGER, which is used live
  input wire logic CFG_WRITE,
  input wire logic [1:0] CAPTURE_MODE_SELECT,
  input wire logic [15:0] MULTI_CAPTURE_COUNT,
  input wire logic [15:0] BURST_CAPTURE_COUNT,
  input wire logic MANUAL_RATE_ENABLE,
  input wire logic [19:0] TARGET_RATE_HZ,
  input wire logic [19:0] ROW_CAPTURE_RATE,
  input wire logic EXPOSURE_CONTROL_SELECT,
  input wire logic [19:0] EXPOSURE_DURATION_US,
  input wire logic [1:0] AUTO_EXPOSURE_REQ,
  input wire logic BURST_FINISH_TRIGGER,
  // Per-kind trigger settings, taken on TRIG_CFG_WRITE
  input wire logic TRIG_CFG_WRITE,
  input wire logic [1:0] TRIGGER_KIND_SELECT,
  input wire logic TRIGGER_ENABLE,
  input wire logic [3:0] TRIGGER_ORIGIN_SELECT,
  input wire logic [2:0] TRIGGER_POLARITY_SELECT,
  input wire logic TRIGGER_DURING_READOUT,
  input wire logic [15:0] TRIGGER_LATENCY_US,
  // Trigger sources
  input wire logic [3:0] TRIG_LINES,
  input wire logic [3:0] USER_OUTPUTS,
  input wire logic [3:0] COUNTER_EVENTS,
  input wire logic [1:0] LOGIC_BLOCKS,
  input wire logic ACTION_EVENT,
  // Image pipeline
  input wire logic READOUT_DONE,
  input wire logic [7:0] LUMA_MEAN,
  // Status
  output logic ACQUISITION_ACTIVE,
  output logic EXPOSURE_ACTIVE,
  output logic READOUT_ACTIVE,
  output logic IMAGE_START,
  output logic ROW_TICK,
  output logic [19:0] ACHIEVED_RATE,
  output logic [1:0] AUTO_EXPOSURE_STATE,
  output logic [19:0] APPLIED_EXPOSURE_US
);
  // ====================================================
  // Settings
  ict_mode_t mode;
  logic [15:0] multi_cnt;
  logic [15:0] burst_cnt;
  logic rate_en;
  logic [19:0] target_rate;
  logic [19:0] row_rate;
  ict_exp_t exp_sel;
  logic [19:0] exp_us;
  ict_ae_t ae_sel;
  logic [19:0] ae_exp;
  logic [3:0] ae_frames;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mode <= ict_mode_t'(`ICT_RST_MODE);
      multi_cnt <= `ICT_RST_COUNT;
      burst_cnt <= `ICT_RST_COUNT;
      rate_en <= 1'b0;
      target_rate <= `ICT_RST_RATE;
      row_rate <= `ICT_RST_ROW_RATE;
      exp_sel <= EXP_TIMED;
      exp_us <= `ICT_RST_EXPOSE_US;
    end else if (CFG_WRITE) begin
      mode <= ict_mode_t'(CAPTURE_MODE_SELECT);
      multi_cnt <= MULTI_CAPTURE_COUNT;
      burst_cnt <= BURST_CAPTURE_COUNT;
      rate_en <= MANUAL_RATE_ENABLE;
      target_rate <= TARGET_RATE_HZ;
      row_rate <= ROW_CAPTURE_RATE;
      exp_sel <= ict_exp_t'(EXPOSURE_CONTROL_SELECT);
      exp_us <= EXPOSURE_DURATION_US;
    end
  end

  // ====================================================
  // Trigger inputs; pins are synchronised, internal sources are not
  logic [3:0] line_meta;
  logic [3:0] line_sync;
  logic [15:0] sources;
  logic trig_en [3];
  logic ovl [3];
  logic [3:0] origin [3];
  ict_pol_t pol [3];
  logic [15:0] latency [3];
  logic [2:0] fire;
  logic [2:0] det_level;
  logic [2:0] det_event;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      line_meta <= 4'h0;
      line_sync <= 4'h0;
    end else begin
      line_meta <= TRIG_LINES;
      line_sync <= line_meta;
    end
  end

  assign sources = {ACTION_EVENT, LOGIC_BLOCKS, COUNTER_EVENTS, USER_OUTPUTS, line_sync, 1'b0};

  for (genvar k = 0; k < 3; k++) begin : g_kind
    always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
        trig_en[k] <= 1'b0;
        ovl[k] <= 1'b0;
        origin[k] <= `ICT_ORIGIN_SOFT;
        pol[k] <= ict_pol_t'(`ICT_RST_POL);
        latency[k] <= `ICT_RST_LATENCY;
      end else if (TRIG_CFG_WRITE && TRIGGER_KIND_SELECT == 2'(k)) begin
        trig_en[k] <= TRIGGER_ENABLE;
        ovl[k] <= TRIGGER_DURING_READOUT;
        origin[k] <= TRIGGER_ORIGIN_SELECT;
        pol[k] <= ict_pol_t'(TRIGGER_POLARITY_SELECT);
        latency[k] <= TRIGGER_LATENCY_US;
      end
    end

    ict_trig_detect u_detect (
      .core_clk(CORE_CLK),
      .rst(RST),
      .sources(sources),
      .soft_pulse(SOFT_TRIGGER_CMD && TRIGGER_KIND_SELECT == 2'(k)),
      .origin(origin[k]),
      .polarity(pol[k]),
      .event_pulse(det_event[k]),
      .level_on(det_level[k])
    );
    assign fire[k] = trig_en[k] & det_event[k];
  end

  // ====================================================
  // Sequencer decode
  ict_state_t state;
  ict_state_t next_state;
  logic [15:0] batch_left;
  logic [15:0] next_batch;
  logic batch_inf;
  logic next_inf;
  logic [15:0] lat;
  logic [15:0] next_lat;
  logic [6:0] us_div;
  logic [19:0] us_cnt;
  logic readout_busy;
  logic pace_pend;
  logic frame_tick;
  logic per_img_on;
  logic burst_on;
  logic framed;
  logic [1:0] fk;
  logic frame_fire;
  logic ovl_sel;
  logic readout_ok;
  logic [15:0] mode_count;
  logic [15:0] burst_len;
  logic [15:0] trig_len;
  logic pending;
  logic can_start;
  logic accept;
  logic start_img;
  logic stop_after;
  logic pulse_mode;
  logic us_tick;
  logic [19:0] exp_raw;
  logic [19:0] exp_eff;
  logic expo_end;
  logic delay_end;
  logic arm_inf;
  logic [15:0] arm_batch;

  // Per-image wins when both frame-level kinds are enabled
  assign per_img_on = trig_en[`ICT_KIND_IMAGE];
  assign burst_on = trig_en[`ICT_KIND_BURST] & ~per_img_on;
  assign framed = per_img_on | burst_on;
  assign fk = per_img_on ? 2'(`ICT_KIND_IMAGE) : 2'(`ICT_KIND_BURST);
  assign frame_fire = framed & fire[fk];
  assign ovl_sel = ovl[fk];
  assign readout_ok = ~readout_busy | ovl_sel;
  assign mode_count = (mode == MODE_ONE_SHOT) ? 16'h0001 :
      (mode == MODE_COUNTED) ? multi_cnt : 16'h0000;
  assign burst_len = (mode != MODE_CONTINUOUS) ? mode_count :
      (BURST_FINISH_TRIGGER ? 16'h0001 : burst_cnt);
  assign trig_len = !per_img_on ? burst_len :
      ((mode == MODE_CONTINUOUS) ? 16'h0001 : mode_count);
  assign pending = batch_inf | (batch_left != 16'h0000);
  assign can_start = pending & readout_ok & (~rate_en | pace_pend);
  assign accept = ~pending & frame_fire & readout_ok;
  assign start_img = state == ST_ARMED && !CAPTURE_HALT_CMD && can_start;
  assign stop_after = ~burst_on & (~per_img_on | (mode != MODE_CONTINUOUS));
  assign arm_inf = ~framed & (mode == MODE_CONTINUOUS);
  assign arm_batch = framed ? 16'h0000 : mode_count;
  assign pulse_mode = (exp_sel == EXP_PULSE_LENGTH) & framed;
  assign us_tick = (us_div == 7'(`ICT_CYC_PER_US - 1));
  assign exp_raw = (ae_sel != AE_OFF) ? ae_exp : exp_us;
  assign exp_eff = (exp_raw == 20'h00000) ? 20'h00001 : exp_raw;
  assign expo_end = (state == ST_EXPOSE) && (pulse_mode ? ~det_level[fk] :
      (us_tick && (us_cnt + 20'h00001) >= exp_eff));
  assign delay_end = (state == ST_DELAY) && us_tick && (us_cnt + 20'h00001) >= {4'h0, lat};

  always_comb begin
    next_state = state;
    next_batch = batch_left;
    next_inf = batch_inf;
    next_lat = lat;
    if (CAPTURE_HALT_CMD) begin
      next_state = ST_IDLE;
      next_batch = 16'h0000;
      next_inf = 1'b0;
      next_lat = 16'h0000;
    end else begin
      case (state)
        ST_IDLE: if (CAPTURE_BEGIN_CMD) begin
          if (trig_en[`ICT_KIND_ACQ]) begin
            next_state = ST_WAIT_ACQ;
          end else begin
            next_state = ST_ARMED;
            next_batch = arm_batch;
            next_inf = arm_inf;
          end
        end
        ST_WAIT_ACQ: if (fire[`ICT_KIND_ACQ]) begin
          next_state = ST_ARMED;
          next_batch = arm_batch;
          next_inf = arm_inf;
          next_lat = latency[`ICT_KIND_ACQ];
        end
        ST_ARMED: if (accept) begin
          next_batch = trig_len;
          next_lat = latency[fk];
        end else if (can_start) begin
          next_batch = batch_inf ? batch_left : batch_left - 16'h0001;
          next_state = (lat != 16'h0000) ? ST_DELAY : ST_EXPOSE;
        end
        ST_DELAY: if (delay_end) begin
          next_state = ST_EXPOSE;
          next_lat = 16'h0000;
        end
        ST_EXPOSE: if (expo_end) begin
          next_state = (!pending && stop_after) ? ST_IDLE : ST_ARMED;
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // ====================================================
  // Sequencer state
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      batch_left <= 16'h0000;
      batch_inf <= 1'b0;
      lat <= 16'h0000;
    end else begin
      state <= next_state;
      batch_left <= next_batch;
      batch_inf <= next_inf;
      lat <= next_lat;
    end
  end

  // Microsecond base restarts on every state change so waits are exact
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      us_div <= 7'h00;
      us_cnt <= 20'h00000;
    end else begin
      us_div <= (next_state != state || us_tick) ? 7'h00 : us_div + 7'h01;
      us_cnt <= (next_state != state) ? 20'h00000 : (us_tick ? us_cnt + 20'h00001 : us_cnt);
    end
  end

  // Set wins over clear for both flags
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      readout_busy <= 1'b0;
      pace_pend <= 1'b0;
      IMAGE_START <= 1'b0;
      APPLIED_EXPOSURE_US <= 20'h00000;
    end else begin
      readout_busy <= expo_end | (readout_busy & ~READOUT_DONE);
      pace_pend <= rate_en & (frame_tick | (pace_pend & ~start_img));
      IMAGE_START <= start_img;
      APPLIED_EXPOSURE_US <= exp_eff;
    end
  end

  ict_rate_gen u_frame_rate (
    .core_clk(CORE_CLK),
    .rst(RST),
    .enable(rate_en),
    .rate_hz(target_rate),
    .tick(frame_tick)
  );

  ict_rate_gen u_row_rate (
    .core_clk(CORE_CLK),
    .rst(RST),
    .enable(readout_busy),
    .rate_hz(row_rate),
    .tick(ROW_TICK)
  );

  // ====================================================
  // Auto exposure: nudges toward mid grey once per finished timed image
  logic ae_step;
  assign ae_step = expo_end && !pulse_mode && ae_sel != AE_OFF;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ae_sel <= ict_ae_t'(`ICT_RST_AE);
      ae_exp <= `ICT_RST_EXPOSE_US;
      ae_frames <= 4'h0;
    end else if (CFG_WRITE) begin
      ae_sel <= ict_ae_t'(AUTO_EXPOSURE_REQ);
      ae_exp <= EXPOSURE_DURATION_US;
      ae_frames <= 4'h0;
    end else if (ae_step) begin
      if (LUMA_MEAN < `ICT_AE_TARGET && ae_exp <= `ICT_AE_MAX_US - `ICT_AE_STEP) begin
        ae_exp <= ae_exp + `ICT_AE_STEP;
      end else if (LUMA_MEAN > `ICT_AE_TARGET && ae_exp > `ICT_AE_STEP) begin
        ae_exp <= ae_exp - `ICT_AE_STEP;
      end
      if (ae_sel == AE_ONCE && ae_frames == `ICT_AE_ONCE_FRAMES - 4'h1) begin
        ae_sel <= AE_OFF;
      end
      ae_frames <= ae_frames + 4'h1;
    end
  end

  // ====================================================
  // Achieved rate: images finished per one-second window
  logic [31:0] win_cnt;
  logic [19:0] win_frames;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      win_cnt <= 32'h00000000;
      win_frames <= 20'h00000;
      ACHIEVED_RATE <= 20'h00000;
    end else if (win_cnt == 32'(RATE_WINDOW_CYC - 1)) begin
      win_cnt <= 32'h00000000;
      win_frames <= 20'h00000;
      ACHIEVED_RATE <= win_frames + {19'h00000, expo_end};
    end else begin
      win_cnt <= win_cnt + 32'h00000001;
      win_frames <= win_frames + {19'h00000, expo_end};
    end
  end

  assign ACQUISITION_ACTIVE = (state != ST_IDLE);
  assign EXPOSURE_ACTIVE = (state == ST_EXPOSE);
  assign READOUT_ACTIVE = readout_busy;
  assign AUTO_EXPOSURE_STATE = ae_sel;

  // ====================================================
  // Checks
  logic [31:0] phase_cyc;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      phase_cyc <= 32'h00000000;
    end else begin
      phase_cyc <= (next_state != state) ? 32'h00000000 : phase_cyc + 32'h00000001;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_begin;
    state == ST_IDLE && CAPTURE_BEGIN_CMD && !CAPTURE_HALT_CMD;
  endsequence
  sequence s_accept;
    state == ST_ARMED && !CAPTURE_HALT_CMD && accept;
  endsequence

  property p_halt; CAPTURE_HALT_CMD |=> state == ST_IDLE; endproperty
  a_halt: assert property (p_halt) else $error("halt ignored");
  property p_begin; s_begin ##0 !trig_en[`ICT_KIND_ACQ] |=> state == ST_ARMED; endproperty
  a_begin: assert property (p_begin) else $error("begin ignored");
  property p_acq_wait;
    state == ST_WAIT_ACQ && !fire[`ICT_KIND_ACQ] && !CAPTURE_HALT_CMD |=> state == ST_WAIT_ACQ;
  endproperty
  a_acq_wait: assert property (p_acq_wait) else $error("left wait without trigger");
  property p_timed;
    expo_end && !pulse_mode |-> phase_cyc == {12'h000, exp_eff} * 32'(`ICT_CYC_PER_US) - 32'h00000001;
  endproperty
  a_timed: assert property (p_timed) else $error("exposure length wrong");
  property p_delay;
    delay_end |-> phase_cyc == {16'h0000, lat} * 32'(`ICT_CYC_PER_US) - 32'h00000001;
  endproperty
  a_delay: assert property (p_delay) else $error("trigger latency wrong");
  property p_one_shot;
    expo_end && mode == MODE_ONE_SHOT && !framed && !CAPTURE_HALT_CMD |=> state == ST_IDLE;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot did not stop");
  property p_cont_image; s_accept ##0 per_img_on && mode == MODE_CONTINUOUS |=> batch_left == 16'h0001; endproperty
  a_cont_image: assert property (p_cont_image) else $error("per-image batch not one");
  property p_burst;
    s_accept ##0 burst_on && mode == MODE_CONTINUOUS && !BURST_FINISH_TRIGGER |=> batch_left == $past(burst_cnt);
  endproperty
  a_burst: assert property (p_burst) else $error("burst length wrong");
  property p_overlap;
    state == ST_ARMED && readout_busy && !ovl_sel && !pending && !CAPTURE_HALT_CMD |=> batch_left == 16'h0000;
  endproperty
  a_overlap: assert property (p_overlap) else $error("trigger taken in readout");
  property p_pace; state == ST_ARMED && rate_en && !pace_pend |-> !start_img; endproperty
  a_pace: assert property (p_pace) else $error("frame started unpaced");
endmodule : ict_capture_seq

// *** hw/ict_map.svh ***
`ifndef ICT_MAP_SVH
`define ICT_MAP_SVH

// ====================================================
// Timing
`define ICT_CLK_PERIOD_NS 10
`define ICT_CLK_HZ 28'd100000000
`define ICT_US_NS 1000
`define ICT_CYC_PER_US ((`ICT_US_NS + `ICT_CLK_PERIOD_NS - 1) / `ICT_CLK_PERIOD_NS)
`define ICT_RATE_WINDOW_NS 1000000000
`define ICT_RATE_WINDOW_CYC (`ICT_RATE_WINDOW_NS / `ICT_CLK_PERIOD_NS)

// ====================================================
// Trigger kind slots and origin codes
`define ICT_KIND_ACQ 0
`define ICT_KIND_IMAGE 1
`define ICT_KIND_BURST 2
`define ICT_ORIGIN_SOFT 4'h0

// ====================================================
// Reset values
`define ICT_RST_MODE 2'h0
`define ICT_RST_COUNT 16'h0001
`define ICT_RST_RATE 20'h0001e
`define ICT_RST_ROW_RATE 20'h0ea60
`define ICT_RST_EXPOSE_US 20'h003e8
`define ICT_RST_AE 2'h2
`define ICT_RST_POL 3'h3
`define ICT_RST_LATENCY 16'h0000

// ====================================================
// Auto exposure loop
`define ICT_AE_TARGET 8'h80
`define ICT_AE_STEP 20'h00010
`define ICT_AE_MAX_US 20'hfffff
`define ICT_AE_ONCE_FRAMES 4'h4

`endif

// *** hw/ict_pkg.sv ***
package ict_pkg;
  typedef enum logic [1:0] {MODE_CONTINUOUS, MODE_COUNTED, MODE_ONE_SHOT} ict_mode_t;
  typedef enum logic [2:0] {POL_LEVEL_LOW, POL_LEVEL_HIGH, POL_FALLING, POL_RISING, POL_ANY_EDGE} ict_pol_t;
  typedef enum logic [1:0] {AE_OFF, AE_ONCE, AE_CONTINUOUS} ict_ae_t;
  typedef enum logic {EXP_TIMED, EXP_PULSE_LENGTH} ict_exp_t;
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_ACQ, ST_ARMED, ST_DELAY, ST_EXPOSE} ict_state_t;
endpackage : ict_pkg

// *** hw/ict_rate_gen.sv ***
`timescale 1ns/1ps
`include "ict_map.svh"
module ict_rate_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Rate in hertz, ticks only while enabled
  input wire logic enable,
  input wire logic [19:0] rate_hz,
  // One pulse per period
  output logic tick
);
  // Phase accumulator gives exact average rate with no divider
  logic [27:0] acc;
  logic [27:0] sum;

  assign sum = acc + {8'h00, rate_hz};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc <= 28'h0000000;
      tick <= 1'b0;
    end else if (!enable) begin
      acc <= 28'h0000000;
      tick <= 1'b0;
    end else if (sum >= `ICT_CLK_HZ) begin
      acc <= sum - `ICT_CLK_HZ;
      tick <= 1'b1;
    end else begin
      acc <= sum;
      tick <= 1'b0;
    end
  end

  property p_tick_gated;
    @(posedge core_clk) disable iff (rst) !enable |=> !tick;
  endproperty
  a_tick_gated: assert property (p_tick_gated) else $error("tick while disabled");
endmodule : ict_rate_gen

// *** hw/ict_trig_detect.sv ***
`timescale 1ns/1ps
`include "ict_map.svh"
module ict_trig_detect import ict_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Sources, all on core_clk
  input wire logic [15:0] sources,
  input wire logic soft_pulse,
  // Selection for this trigger kind
  input wire logic [3:0] origin,
  input wire ict_pol_t polarity,
  // Result
  output logic event_pulse,
  output logic level_on
);
  logic sig;
  logic prev;
  logic is_soft;
  logic hit;
  logic active_low;

  assign is_soft = (origin == `ICT_ORIGIN_SOFT);
  assign sig = sources[origin];
  assign active_low = (polarity == POL_LEVEL_LOW) || (polarity == POL_FALLING);
  assign hit = is_soft ? soft_pulse :
      (polarity == POL_LEVEL_LOW) ? ~sig :
      (polarity == POL_LEVEL_HIGH) ? sig :
      (polarity == POL_FALLING) ? (prev & ~sig) :
      (polarity == POL_RISING) ? (~prev & sig) :
      (polarity == POL_ANY_EDGE) ? (prev ^ sig) : 1'b0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev <= 1'b0;
      event_pulse <= 1'b0;
      level_on <= 1'b0;
    end else begin
      prev <= sig;
      event_pulse <= hit;
      level_on <= ~is_soft & (active_low ? ~sig : sig);
    end
  end

  property p_soft_fires;
    @(posedge core_clk) disable iff (rst) is_soft && soft_pulse |=> event_pulse;
  endproperty
  a_soft_fires: assert property (p_soft_fires) else $error("soft trigger lost");

  property p_edge_single;
    @(posedge core_clk) disable iff (rst)
      polarity == POL_RISING && !is_soft && $stable(origin) && event_pulse |=> !event_pulse;
  endproperty
  a_edge_single: assert property (p_edge_single) else $error("edge counted twice");
endmodule : ict_trig_detect

// *** testbench/ict_capture_seq_tb.sv ***
`timescale 1ns/1ps
module ict_capture_seq_tb import ict_pkg::*;;
  logic CORE_CLK = 0, RST = 1, bgn = 0, hlt = 0, sft = 0, cw = 0, tw = 0, ten = 0, ren = 0, xsel = 0, ovr = 0, done;
  logic [1:0] mode = 0, ae = 0, kind = 0;
  logic [15:0] mcnt = 0, bcnt = 0, tlat = 0;
  logic [19:0] rate = 0, row = 0, exp_us = 0, arate, applied;
  logic [3:0] orig = 0, lines = 0;
  logic [2:0] pol = 0;
  logic [7:0] lag = 0, luma;
  logic acq, expo, rd, img, rtick;
  logic [1:0] aes;
  int errors = 0, cmp_count = 0, imgs = 0, run = 0, last_len = 0, cycles = 0, rows = 0, t_sft = 0, t_exp = 0, b, e, n, r;
  always #5 CORE_CLK = ~CORE_CLK;
  ict_capture_seq #(.RATE_WINDOW_CYC(1000)) i_ict_capture_seq (.CORE_CLK(CORE_CLK), .RST(RST),
    .CAPTURE_BEGIN_CMD(bgn), .CAPTURE_HALT_CMD(hlt), .SOFT_TRIGGER_CMD(sft), .CFG_WRITE(cw),
    .CAPTURE_MODE_SELECT(mode), .MULTI_CAPTURE_COUNT(mcnt), .BURST_CAPTURE_COUNT(bcnt),
    .MANUAL_RATE_ENABLE(ren), .TARGET_RATE_HZ(rate), .ROW_CAPTURE_RATE(row),
    .EXPOSURE_CONTROL_SELECT(xsel), .EXPOSURE_DURATION_US(exp_us), .AUTO_EXPOSURE_REQ(ae),
    .BURST_FINISH_TRIGGER(1'b0), .TRIG_CFG_WRITE(tw), .TRIGGER_KIND_SELECT(kind), .TRIGGER_ENABLE(ten),
    .TRIGGER_ORIGIN_SELECT(orig), .TRIGGER_POLARITY_SELECT(pol), .TRIGGER_DURING_READOUT(ovr),
    .TRIGGER_LATENCY_US(tlat), .TRIG_LINES(lines), .USER_OUTPUTS(4'h0), .COUNTER_EVENTS(4'h0),
    .LOGIC_BLOCKS(2'h0), .ACTION_EVENT(1'b0), .READOUT_DONE(done), .LUMA_MEAN(luma),
    .ACQUISITION_ACTIVE(acq), .EXPOSURE_ACTIVE(expo), .READOUT_ACTIVE(rd), .IMAGE_START(img),
    .ROW_TICK(rtick), .ACHIEVED_RATE(arate), .AUTO_EXPOSURE_STATE(aes), .APPLIED_EXPOSURE_US(applied));
  ict_pipe_model i_ict_pipe_model (.CORE_CLK(CORE_CLK), .RST(RST), .READOUT_ACTIVE(rd), .lag(lag),
    .READOUT_DONE(done), .LUMA_MEAN(luma));
  // ====================================================
  // Image and exposure-length monitors, plus the hang guard
  always @(posedge CORE_CLK) begin
    if (expo === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
    if (img === 1'b1) imgs <= imgs + 1;
    if (expo === 1'b1 && run == 0) t_exp <= cycles;
    if (sft === 1'b1) t_sft <= cycles;
    if (rtick === 1'b1) rows <= rows + 1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    cmp_count++;
    if (seen !== want) begin
      errors++;
      $display("BAD %0t saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // Command strobes: 0 begin, 1 halt, 2 soft trigger
  task automatic cmd(input int k);
    @(posedge CORE_CLK);
    {bgn, hlt, sft} <= 3'b100 >> k;
    @(posedge CORE_CLK);
    {bgn, hlt, sft} <= 3'b000;
  endtask : cmd
  task automatic cfg(input logic [1:0] m, input int c, input int us, input logic [1:0] a, input logic man = 1'b0,
    input logic pw = 1'b0);
    @(posedge CORE_CLK);
    {mode, mcnt, exp_us, ae, cw, ren, xsel} <= {m, 16'(c), 20'(us), a, 1'b1, man, pw};
    // Manual pacing runs 100 kHz with a long readout and fast rows, so row ticks show up
    {bcnt, rate, row, lag} <= man ? {16'h0001, 20'h186a0, 20'hfffff, 8'hc8} : {16'($urandom),
      20'($urandom_range(2000, 1)), 20'($urandom_range(60000, 1)), 8'($urandom_range(30, 0))};
    @(posedge CORE_CLK);
    cw <= 1'b0;
  endtask : cfg
  task automatic tcfg(input logic en, input logic [3:0] o, input logic [15:0] l = 16'h0000);
    @(posedge CORE_CLK);
    {kind, ten, orig, pol, tw, tlat} <= {2'h1, en, o, POL_RISING, 1'b1, l};
    // Overlap only matters when a trigger meets a readout, and triggers here are spaced apart
    ovr <= 1'($urandom);
    @(posedge CORE_CLK);
    tw <= 1'b0;
  endtask : tcfg
  // Triggers are spaced past exposure plus readout so none is refused
  task automatic fire(input int k, input logic line);
    repeat (k) begin
      if (line) begin
        @(posedge CORE_CLK) lines[0] <= 1'b1;
        repeat (50) @(posedge CORE_CLK);
        lines[0] <= 1'b0;
      end else cmd(2);
      repeat (400) @(posedge CORE_CLK);
    end
  endtask : fire
  initial begin
    void'($urandom(32'h6291));
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    #1;
    check(applied, 20'd1000);
    check(20'(aes), 20'(AE_CONTINUOUS));
    check(20'(acq), 20'h0);
    for (int m = 0; m < 3; m++) begin
      e = $urandom_range(3, 1);
      n = $urandom_range(3, 2);
      cfg(m[1:0], n, e, AE_OFF);
      b = imgs;
      cmd(0);
      // The begin edge shows in status only one edge later
      @(posedge CORE_CLK);
      // Free-run waits for the third exposure to end so its length is whole
      for (int i = 0; i < 4000 && (m == 0 ? (imgs - b < 3 || expo !== 1'b0) : acq !== 1'b0); i++)
        @(posedge CORE_CLK);
      if (m == 0) cmd(1);
      repeat (2) @(posedge CORE_CLK);
      check(20'(acq), 20'h0);
      if (m != 0) check(20'(imgs - b), m == 1 ? 20'(n) : 20'h1);
      check(20'(last_len), 20'(e * 100));
    end
    cfg(MODE_CONTINUOUS, 1, 1, AE_OFF, 1'b1);
    b = imgs;
    r = rows;
    cmd(0);
    // One image per 1000-cycle frame period, and one per rate window
    repeat (2500) @(posedge CORE_CLK);
    check(20'(imgs - b), 20'h2);
    check(arate, 20'h1);
    check(20'(rows - r), 20'h4);
    cmd(1);
    cfg(MODE_CONTINUOUS, 1, 1, AE_ONCE);
    b = imgs;
    cmd(0);
    for (int i = 0; i < 4000 && imgs - b < 6; i++) @(posedge CORE_CLK);
    check(20'(aes), 20'(AE_OFF));
    cmd(1);
    n = $urandom_range(2, 0);
    tcfg(1'b1, 4'h0, 16'(n));
    cfg(MODE_CONTINUOUS, 1, 1, AE_OFF);
    b = imgs;
    cmd(0);
    repeat (300) @(posedge CORE_CLK);
    check(20'(imgs - b), 20'h0);
    fire(3, 1'b0);
    check(20'(imgs - b), 20'h3);
    // Detect, load and arm take three cycles ahead of the programmed delay
    check(20'(t_exp - t_sft), 20'(n * 100 + 3));
    cmd(1);
    cfg(MODE_ONE_SHOT, 1, 1, AE_OFF);
    b = imgs;
    cmd(0);
    fire(2, 1'b0);
    check(20'(imgs - b), 20'h1);
    tcfg(1'b1, 4'h1);
    cfg(MODE_CONTINUOUS, 1, 1, AE_OFF, 1'b0, 1'b1);
    b = imgs;
    cmd(0);
    fire(2, 1'b1);
    check(20'(imgs - b), 20'h2);
    // Exposure follows the 50-cycle pulse; its end passes one stage fewer than its start
    check(20'(last_len), 20'h31);
    cmd(1);
    report_and_stop();
  end
endmodule : ict_capture_seq_tb

// *** testbench/ict_pipe_model.sv ***
`timescale 1ns/1ps
// ====================================================
// Readout pipeline stand-in, answers each readout lag plus one cycles after it starts
module ict_pipe_model (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Handshake with the sequencer
  input wire logic READOUT_ACTIVE,
  input wire logic [7:0] lag,
  output logic READOUT_DONE,
  output logic [7:0] LUMA_MEAN
);
  logic [7:0] cnt;
  logic busy;
  // Mid-grey keeps the auto loop still, so exposure stays predictable
  assign LUMA_MEAN = 8'h80;
  assign busy = READOUT_ACTIVE && !READOUT_DONE;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt <= 8'h00;
      READOUT_DONE <= 1'b0;
    end else begin
      READOUT_DONE <= busy && cnt == lag;
      cnt <= (busy && cnt != lag) ? cnt + 8'h01 : 8'h00;
    end
  end
endmodule : ict_pipe_model
